// file: lnbp_defines.svh
// Register offsets, field positions and reset values of the protection configuration block
`ifndef LNBP_DEFINES_SVH
`define LNBP_DEFINES_SVH

// Internal register addresses
`define LNBP_ADDR_STATUS     8'h00
`define LNBP_ADDR_VOLTSEL    8'h02
`define LNBP_ADDR_CURLIM     8'h04
`define LNBP_ADDR_PROTCOMP   8'h05

// Current-limit register fields
`define LNBP_PULSE_OFF_A_BIT 2
`define LNBP_PULSE_OFF_B_BIT 6

// Protection / compensation register fields
`define LNBP_OL_MANUAL_BIT   3
`define LNBP_OT_MANUAL_BIT   6
`define LNBP_COMP_BIT        7

// Status register fields
`define LNBP_OL_FLAG_A_BIT   0
`define LNBP_OL_FLAG_B_BIT   1
`define LNBP_OT_FLAG_BIT     6

// Reset values
`define LNBP_CURLIM_RST      8'h00
`define LNBP_PROTCOMP_RST    8'h00
`define LNBP_VOLTSEL_RST     8'h00
// Synchroniser reset: bus lines at idle high, detectors low
`define LNBP_SYNC_RST        5'h03

// Serial framing
`define LNBP_BITS_PER_BYTE   4'h8
`define LNBP_CHIP_ADDR_RST   7'h08

`endif

// file: lnbp_pkg.sv
// Types shared by the protection configuration block
`default_nettype none
package lnbp_pkg;

  typedef logic [7:0] lnbp_byte_t;

  // Serial slave states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_DEVADDR = 7'h02,
    ST_ACK     = 7'h04,
    ST_REGADDR = 7'h08,
    ST_WRITE   = 7'h10,
    ST_READ    = 7'h20,
    ST_MACK    = 7'h40
  } lnbp_state_e;

endpackage
`default_nettype wire

// file: lnbp_prot_if.sv
// Signals between the register bank and the protection logic
`timescale 1ns/1ps
`default_nettype none
interface lnbp_prot_if;
  logic [7:0] voltSel;
  logic       olManual;
  logic       otManual;
  logic [1:0] olFlag;
  logic       otFlag;
  logic [1:0] clearVoltSel;
  logic [1:0] outEnable;

  modport ctrl (output voltSel, olManual, otManual, olFlag, otFlag, input clearVoltSel, outEnable);
  modport prot (input voltSel, olManual, otManual, olFlag, otFlag, output clearVoltSel, outEnable);
endinterface
`default_nettype wire

// file: lnbp_protect.sv
// Overload and overtemperature recovery logic for both output channels
`timescale 1ns/1ps
`default_nettype none
module lnbp_protect
  import lnbp_pkg::*;
(
  // Clock and reset
  input  wire logic   mclk,
  input  wire logic   rst_b,
  // Link to the register bank
  lnbp_prot_if.prot   pif
);

  logic [1:0] clearVoltSel_reg;
  logic [1:0] clearVoltSel_next;
  logic [1:0] outEnable_reg;
  logic [1:0] outEnable_next;

  // Per channel clear request and output enable
  always_comb begin
    for (int ch = 0; ch < 2; ch++) begin
      // Level clear, so a rewrite during the fault cannot re-arm the output
      clearVoltSel_next[ch] = (pif.olManual & pif.olFlag[ch])
                            | (pif.otManual & pif.otFlag);
      // Output follows the retained selection once no fault is present
      outEnable_next[ch] = ~pif.olFlag[ch] & ~pif.otFlag
                         & (pif.voltSel[ch*4 +: 4] != 4'h0);
    end
  end

  // Register the results
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      clearVoltSel_reg <= 2'h0;
      outEnable_reg <= 2'h0;
    end else begin
      clearVoltSel_reg <= clearVoltSel_next;
      outEnable_reg <= outEnable_next;
    end
  end

  assign pif.clearVoltSel = clearVoltSel_reg;
  assign pif.outEnable = outEnable_reg;

endmodule
`default_nettype wire

// file: lnbp_config_regs.sv
// Serial-bus configuration registers of a dual-channel LNB supply controller
`timescale 1ns/1ps
`default_nettype none
`include "lnbp_defines.svh"
module lnbp_config_regs
  import lnbp_pkg::*;
#(
  parameter logic [6:0] CHIP_ADDR = `LNBP_CHIP_ADDR_RST // Arbitrary default
)(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // Serial bus pins
  input  wire logic       scl,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  // Analogue fault detectors
  input  wire logic [1:0] overloadDetect,
  input  wire logic       overtempDetect,
  // Regulator controls
  output logic [7:0]      outputVoltageSelect,
  output logic [1:0]      outputEnable,
  output logic            pulseLimitOffChA,
  output logic            pulseLimitOffChB,
  output logic            compLowEsr,
  // Diagnostic flags
  output logic [1:0]      overloadFlag,
  output logic            overtempFlag
);

  localparam int NSYNC = 5;

  lnbp_prot_if pif ();

  // Input synchronisers: scl, sda, overload A/B, overtemp
  logic [NSYNC-1:0] rawIn;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic [NSYNC-1:0] sync3_reg;
  logic [NSYNC-1:0] filt_reg;
  logic [NSYNC-1:0] filt_next;

  assign rawIn = {overtempDetect, overloadDetect, sdaIn, scl};

  // A change counts only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_filt
      always_comb begin
        filt_next[gi] = (sync2_reg[gi] == sync3_reg[gi]) ? sync3_reg[gi] : filt_reg[gi];
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      // Idle-high bus reset keeps the edge detectors free of false edges
      sync1_reg <= `LNBP_SYNC_RST;
      sync2_reg <= `LNBP_SYNC_RST;
      sync3_reg <= `LNBP_SYNC_RST;
      filt_reg  <= `LNBP_SYNC_RST;
    end else begin
      sync1_reg <= rawIn;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg  <= filt_next;
    end
  end

  // Edge and condition detection on the cleaned bus lines
  logic sclQ;
  logic sdaQ;
  logic sclPrev_reg;
  logic sdaPrev_reg;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;

  assign sclQ      = filt_reg[0];
  assign sdaQ      = filt_reg[1];
  assign sclRise   = sclQ & ~sclPrev_reg;
  assign sclFall   = ~sclQ & sclPrev_reg;
  assign startCond = sclQ & sclPrev_reg & sdaPrev_reg & ~sdaQ;
  assign stopCond  = sclQ & sclPrev_reg & ~sdaPrev_reg & sdaQ;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end else begin
      sclPrev_reg <= sclQ;
      sdaPrev_reg <= sdaQ;
    end
  end

  // Register bank state
  lnbp_byte_t  voltSel_reg;
  lnbp_byte_t  voltSel_next;
  lnbp_byte_t  curLim_reg;
  lnbp_byte_t  curLim_next;
  lnbp_byte_t  protComp_reg;
  lnbp_byte_t  protComp_next;

  // Serial slave state
  lnbp_state_e state_reg;
  lnbp_state_e state_next;
  logic [3:0]  bitCnt_reg;
  logic [3:0]  bitCnt_next;
  lnbp_byte_t  shift_reg;
  lnbp_byte_t  shift_next;
  lnbp_byte_t  regPtr_reg;
  lnbp_byte_t  regPtr_next;
  logic        isRead_reg;
  logic        isRead_next;
  logic        gotReg_reg;
  logic        gotReg_next;
  logic        masterAck_reg;
  logic        masterAck_next;
  logic        sdaOe_reg;
  logic        sdaOe_next;

  // Read decode, used for the first byte and for every auto-increment
  function automatic lnbp_byte_t readMux(input lnbp_byte_t addr);
    lnbp_byte_t statusByte;
    statusByte = 8'h00;
    statusByte[`LNBP_OL_FLAG_A_BIT] = pif.olFlag[0];
    statusByte[`LNBP_OL_FLAG_B_BIT] = pif.olFlag[1];
    statusByte[`LNBP_OT_FLAG_BIT]   = pif.otFlag;
    if (addr == `LNBP_ADDR_STATUS) begin
      readMux = statusByte;
    end else if (addr == `LNBP_ADDR_VOLTSEL) begin
      readMux = voltSel_reg;
    end else if (addr == `LNBP_ADDR_CURLIM) begin
      readMux = curLim_reg;
    end else if (addr == `LNBP_ADDR_PROTCOMP) begin
      readMux = protComp_reg;
    end else begin
      readMux = 8'h00;
    end
  endfunction

  // Slave sequencing and register writes
  always_comb begin
    state_next     = state_reg;
    bitCnt_next    = bitCnt_reg;
    shift_next     = shift_reg;
    regPtr_next    = regPtr_reg;
    isRead_next    = isRead_reg;
    gotReg_next    = gotReg_reg;
    masterAck_next = masterAck_reg;
    voltSel_next   = voltSel_reg;
    curLim_next    = curLim_reg;
    protComp_next  = protComp_reg;

    if (startCond) begin
      // Repeated start restarts framing from any state
      state_next  = ST_DEVADDR;
      bitCnt_next = 4'h0;
      gotReg_next = 1'b0;
    end else if (stopCond) begin
      state_next = ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          bitCnt_next = 4'h0;
        end
        ST_DEVADDR, ST_REGADDR, ST_WRITE: begin
          if (sclRise && bitCnt_reg != `LNBP_BITS_PER_BYTE) begin
            shift_next  = {shift_reg[6:0], sdaQ};
            bitCnt_next = bitCnt_reg + 4'h1;
          end else if (sclFall && bitCnt_reg == `LNBP_BITS_PER_BYTE) begin
            bitCnt_next = 4'h0;
            state_next  = ST_ACK;
            if (state_reg == ST_DEVADDR) begin
              isRead_next = shift_reg[0];
              if (shift_reg[7:1] != CHIP_ADDR) begin
                state_next = ST_IDLE; // Not ours: stay off the bus
              end
            end else if (state_reg == ST_REGADDR) begin
              regPtr_next = shift_reg;
              gotReg_next = 1'b1;
            end else begin
              // Write decode; reserved bits are stored as sent
              if (regPtr_reg == `LNBP_ADDR_VOLTSEL) begin
                voltSel_next = shift_reg;
              end else if (regPtr_reg == `LNBP_ADDR_CURLIM) begin
                curLim_next = shift_reg;
              end else if (regPtr_reg == `LNBP_ADDR_PROTCOMP) begin
                protComp_next = shift_reg;
              end
              regPtr_next = regPtr_reg + 8'h01;
            end
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            if (isRead_reg) begin
              shift_next = readMux(regPtr_reg);
              state_next = ST_READ;
            end else if (!gotReg_reg) begin
              state_next = ST_REGADDR;
            end else begin
              state_next = ST_WRITE;
            end
          end
        end
        ST_READ: begin
          if (sclRise) begin
            bitCnt_next = bitCnt_reg + 4'h1;
          end else if (sclFall) begin
            if (bitCnt_reg == `LNBP_BITS_PER_BYTE) begin
              bitCnt_next = 4'h0;
              state_next  = ST_MACK;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
            end
          end
        end
        ST_MACK: begin
          if (sclRise) begin
            masterAck_next = ~sdaQ;
          end else if (sclFall) begin
            if (masterAck_reg) begin
              regPtr_next = regPtr_reg + 8'h01;
              shift_next  = readMux(regPtr_reg + 8'h01);
              state_next  = ST_READ;
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end

    // Protection clear overrides a master write in the same cycle
    for (int ch = 0; ch < 2; ch++) begin
      if (pif.clearVoltSel[ch]) begin
        voltSel_next[ch*4 +: 4] = 4'h0;
      end
    end

    // Open-drain: pull low for our ack and for zero data bits
    sdaOe_next = (state_next == ST_ACK) | ((state_next == ST_READ) & ~shift_next[7]);
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_reg     <= ST_IDLE;
      bitCnt_reg    <= 4'h0;
      shift_reg     <= 8'h00;
      regPtr_reg    <= 8'h00;
      isRead_reg    <= 1'b0;
      gotReg_reg    <= 1'b0;
      masterAck_reg <= 1'b0;
      sdaOe_reg     <= 1'b0;
      voltSel_reg   <= `LNBP_VOLTSEL_RST;
      curLim_reg    <= `LNBP_CURLIM_RST;
      protComp_reg  <= `LNBP_PROTCOMP_RST;
    end else begin
      state_reg     <= state_next;
      bitCnt_reg    <= bitCnt_next;
      shift_reg     <= shift_next;
      regPtr_reg    <= regPtr_next;
      isRead_reg    <= isRead_next;
      gotReg_reg    <= gotReg_next;
      masterAck_reg <= masterAck_next;
      sdaOe_reg     <= sdaOe_next;
      voltSel_reg   <= voltSel_next;
      curLim_reg    <= curLim_next;
      protComp_reg  <= protComp_next;
    end
  end

  // Feed the protection logic
  assign pif.voltSel  = voltSel_reg;
  assign pif.olManual = protComp_reg[`LNBP_OL_MANUAL_BIT];
  assign pif.otManual = protComp_reg[`LNBP_OT_MANUAL_BIT];
  assign pif.olFlag   = filt_reg[3:2];
  assign pif.otFlag   = filt_reg[4];

  lnbp_protect u_protect (
    .mclk  (mclk),
    .rst_b (rst_b),
    .pif   (pif)
  );

  // Pin and control outputs, all from flip-flops except sdaOut, tied low
  assign sdaOut              = 1'b0;
  assign sdaOe               = sdaOe_reg;
  assign outputVoltageSelect = voltSel_reg;
  assign outputEnable        = pif.outEnable;
  assign pulseLimitOffChA    = curLim_reg[`LNBP_PULSE_OFF_A_BIT];
  assign pulseLimitOffChB    = curLim_reg[`LNBP_PULSE_OFF_B_BIT];
  assign compLowEsr          = protComp_reg[`LNBP_COMP_BIT];
  assign overloadFlag        = filt_reg[3:2];
  assign overtempFlag        = filt_reg[4];

endmodule
`default_nettype wire

// file: lnbp_config_regs_checker.sv
// Port-level checker for the protection configuration block
`timescale 1ns/1ps
`default_nettype none
module lnbp_config_regs_checker (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst_b,
  // Serial bus pins
  input wire logic       scl,
  input wire logic       sdaIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  // Fault detectors
  input wire logic [1:0] overloadDetect,
  input wire logic       overtempDetect,
  // Regulator controls and flags
  input wire logic [7:0] outputVoltageSelect,
  input wire logic [1:0] outputEnable,
  input wire logic       pulseLimitOffChA,
  input wire logic       pulseLimitOffChB,
  input wire logic       compLowEsr,
  input wire logic [1:0] overloadFlag,
  input wire logic       overtempFlag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Channel outputs follow flags and selection one cycle later
  property p_oenA;
    outputEnable[0] == $past(!overloadFlag[0] && !overtempFlag && outputVoltageSelect[3:0] != 4'h0);
  endproperty
  a_oenA: assert property (p_oenA) else $error("channel A enable wrong");
  property p_oenB;
    outputEnable[1] == $past(!overloadFlag[1] && !overtempFlag && outputVoltageSelect[7:4] != 4'h0);
  endproperty
  a_oenB: assert property (p_oenB) else $error("channel B enable wrong");
  // Flags settle to a steady detector within eight cycles
  property p_olf;
    $stable(overloadDetect) [*8] |-> overloadFlag == overloadDetect;
  endproperty
  a_olf: assert property (p_olf) else $error("overload flag wrong");
  property p_otf;
    $stable(overtempDetect) [*8] |-> overtempFlag == overtempDetect;
  endproperty
  a_otf: assert property (p_otf) else $error("overtemp flag wrong");
  property p_otOff;
    overtempFlag |=> outputEnable == 2'b00;
  endproperty
  a_otOff: assert property (p_otOff) else $error("output on during overtemp");
  // Pulse-limit and compensation controls move only after a bus write, never on an idle bus
  property p_cfgStable;
    (scl && sdaIn) [*8] |=> $stable({pulseLimitOffChA, pulseLimitOffChB, compLowEsr});
  endproperty
  a_cfgStable: assert property (p_cfgStable) else $error("control moved on idle bus");
  // Slave must not move sda while scl is high
  property p_oeChg;
    $changed(sdaOe) |-> !scl;
  endproperty
  a_oeChg: assert property (p_oeChg) else $error("sda moved with scl high");
  property p_sdaOut;
    sdaOut == 1'b0;
  endproperty
  a_sdaOut: assert property (p_sdaOut) else $error("open drain drives high");
endmodule
bind lnbp_config_regs lnbp_config_regs_checker lnbp_config_regs_checker_i (.mclk, .rst_b, .scl, .sdaIn,
  .sdaOut, .sdaOe, .overloadDetect, .overtempDetect, .outputVoltageSelect, .outputEnable,
  .pulseLimitOffChA, .pulseLimitOffChB, .compLowEsr, .overloadFlag, .overtempFlag);
`default_nettype wire

// file: lnbp_i2c_master.sv
// Two-wire bus master model facing the configuration block
`timescale 1ns/1ps
`default_nettype none
module lnbp_i2c_master (
  // Clock
  input  wire logic mclk,
  // Bus pins
  input  wire logic sdaOe,
  output logic      scl,
  output logic      sdaIn
);
  logic sdaLow;
  // Open-drain line with pull-up
  assign sdaIn = !(sdaLow || sdaOe);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // Ten cycles per phase, above the slave's filter delay
  task automatic hp();
    repeat (10) @(posedge mclk);
  endtask
  task automatic start();
    sdaLow <= 1'b0;
    hp();
    scl <= 1'b1;
    hp();
    sdaLow <= 1'b1;
    hp();
    scl <= 1'b0;
    hp();
  endtask
  task automatic stop();
    sdaLow <= 1'b1;
    hp();
    scl <= 1'b1;
    hp();
    sdaLow <= 1'b0;
    hp();
  endtask
  // Data moves mid-low, sampled at end of high
  task automatic bitx(input logic b, output logic r);
    sdaLow <= !b;
    hp();
    scl <= 1'b1;
    hp();
    r = sdaIn;
    scl <= 1'b0;
    hp();
  endtask
  task automatic xbyte(input logic [7:0] d, input logic mAck, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(mAck, ack);
  endtask
  // Single-byte write; nak bits are chip, pointer, data
  task automatic wr(input logic [6:0] ca, input logic [7:0] a, input logic [7:0] d, output logic [2:0] nak);
    logic [7:0] q;
    start();
    xbyte({ca, 1'b0}, 1'b1, q, nak[2]);
    xbyte(a, 1'b1, q, nak[1]);
    xbyte(d, 1'b1, q, nak[0]);
    stop();
  endtask
  // Pointer set, then one byte read ended by a master nack
  task automatic rd(input logic [6:0] ca, input logic [7:0] a, output logic [7:0] d);
    logic [7:0] q;
    logic       k;
    start();
    xbyte({ca, 1'b0}, 1'b1, q, k);
    xbyte(a, 1'b1, q, k);
    stop();
    start();
    xbyte({ca, 1'b1}, 1'b1, q, k);
    xbyte(8'hFF, 1'b1, d, k);
    stop();
  endtask
  // Two-byte write; the pointer steps once per data byte
  task automatic wr2(input logic [6:0] ca, input logic [7:0] a, input logic [15:0] d, output logic [2:0] nak);
    logic [7:0] q;
    logic       k;
    start();
    xbyte({ca, 1'b0}, 1'b1, q, nak[2]);
    xbyte(a, 1'b1, q, nak[1]);
    xbyte(d[15:8], 1'b1, q, k);
    xbyte(d[7:0], 1'b1, q, nak[0]);
    nak[0] = nak[0] | k;
    stop();
  endtask
  // Two-byte read; master acks the first byte to get the next one
  task automatic rd2(input logic [6:0] ca, input logic [7:0] a, output logic [15:0] d);
    logic [7:0] q;
    logic       k;
    start();
    xbyte({ca, 1'b0}, 1'b1, q, k);
    xbyte(a, 1'b1, q, k);
    stop();
    start();
    xbyte({ca, 1'b1}, 1'b1, q, k);
    xbyte(8'hFF, 1'b0, d[15:8], k);
    xbyte(8'hFF, 1'b1, d[7:0], k);
    stop();
  endtask
endmodule
`default_nettype wire

// file: lnbp_config_regs_tb_top.sv
// Self-checking bench for the protection configuration block
`timescale 1ns/1ps
`default_nettype none
module lnbp_config_regs_tb_top;
  localparam logic [6:0] CA = 7'h08; // Arbitrary chip address
  logic       mclk, rst_b, scl, sdaIn, sdaOut, sdaOe, overtempDetect, overtempFlag;
  logic       pulseLimitOffChA, pulseLimitOffChB, compLowEsr;
  logic [1:0] overloadDetect, outputEnable, overloadFlag;
  logic [7:0] outputVoltageSelect, rdv;
  logic [2:0] nak;
  logic [15:0] rdw;
  logic [7:0] pv [4] = '{8'h04, 8'h40, 8'h44, 8'h00};
  int         error_cnt, samples_checked, cycles;

  lnbp_config_regs #(.CHIP_ADDR(CA)) lnbp_config_regs_i (.mclk, .rst_b, .scl, .sdaIn, .sdaOut, .sdaOe,
    .overloadDetect, .overtempDetect, .outputVoltageSelect, .outputEnable, .pulseLimitOffChA,
    .pulseLimitOffChB, .compLowEsr, .overloadFlag, .overtempFlag);
  lnbp_i2c_master lnbp_i2c_master_i (.mclk, .sdaOe, .scl, .sdaIn);

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    lnbp_i2c_master_i.wr(CA, a, d, nak);
    chk({5'h0, nak}, 8'h00);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    lnbp_i2c_master_i.rd(CA, a, rdv);
    chk(rdv, e);
  endtask
  // Fault raised and removed with both channels selected
  task automatic fault(input logic [7:0] pc, input logic [1:0] ol, input logic ot, input logic [7:0] ev,
                       input logic [1:0] eo);
    w(8'h05, pc);
    w(8'h02, 8'h11);
    overloadDetect <= ol;
    overtempDetect <= ot;
    repeat (20) @(posedge mclk);
    chk({6'h0, outputEnable}, {6'h0, ~ol & {2{~ot}}});
    rchk(8'h00, {1'b0, ot, 4'h0, ol});
    overloadDetect <= 2'b00;
    overtempDetect <= 1'b0;
    repeat (20) @(posedge mclk);
    rchk(8'h02, ev);
    chk(outputVoltageSelect, ev);
    chk({6'h0, outputEnable}, {6'h0, eo});
  endtask

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Hang guard, about twice the expected run
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    rst_b = 1'b0;
    overloadDetect = 2'b00;
    overtempDetect = 1'b0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (10) @(posedge mclk);
    rchk(8'h04, 8'h00);
    rchk(8'h05, 8'h00);
    rchk(8'h02, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      w(8'h04, pv[i]);
      rchk(8'h04, pv[i]);
      chk({6'h0, pulseLimitOffChB, pulseLimitOffChA}, {6'h0, pv[i][6], pv[i][2]});
    end
    w(8'h05, 8'h80);
    chk({7'h0, compLowEsr}, 8'h01);
    rchk(8'h05, 8'h80);
    w(8'h05, 8'h00);
    chk({7'h0, compLowEsr}, 8'h00);
    $display("config test done");
    // Wrong chip address is ignored entirely
    lnbp_i2c_master_i.wr(CA ^ 7'h01, 8'h04, 8'h44, nak);
    chk({5'h0, nak}, 8'h07);
    rchk(8'h04, 8'h00);
    $display("address test done");
    // Burst write and burst read walk the pointer across both registers
    lnbp_i2c_master_i.wr2(CA, 8'h04, 16'h4480, nak);
    chk({5'h0, nak}, 8'h00);
    lnbp_i2c_master_i.rd2(CA, 8'h04, rdw);
    chk(rdw[15:8], 8'h44);
    chk(rdw[7:0], 8'h80);
    chk({5'h0, pulseLimitOffChB, pulseLimitOffChA, compLowEsr}, 8'h07);
    $display("burst test done");
    fault(8'h00, 2'b01, 1'b0, 8'h11, 2'b11);
    fault(8'h08, 2'b01, 1'b0, 8'h10, 2'b10);
    fault(8'h00, 2'b00, 1'b1, 8'h11, 2'b11);
    fault(8'h40, 2'b00, 1'b1, 8'h00, 2'b00);
    w(8'h02, 8'h11);
    chk({6'h0, outputEnable}, 8'h03);
    $display("protection test done");
    summarize();
  end
endmodule
`default_nettype wire
